// *** shared/stl_pkg.sv ***
package stl_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] STL_OFS_CTRL = 8'h00;
  localparam logic [7:0] STL_OFS_CFG = 8'h04;
  localparam logic [7:0] STL_OFS_STAT = 8'h08;
  localparam logic [7:0] STL_OFS_PEAK = 8'h0c;

  // field positions in the control and config words
  localparam int STL_CTRL_EN_BIT = 0;
  localparam int STL_CTRL_TYPE_BIT = 1;
  localparam int STL_CFG_FS_LSB = 0;
  localparam int STL_CFG_HR_LSB = 8;
  localparam int STL_CFG_THR_LSB = 16;
  localparam int STL_CFG_KNEE_LSB = 24;

  // values after reset
  localparam logic [4:0] STL_FS_RESET = 5'h00;
  localparam logic [4:0] STL_HR_RESET = 5'h08;
  localparam logic [3:0] STL_THR_RESET = 4'h0;
  localparam logic [3:0] STL_KNEE_RESET = 4'h0;

  // full scale output setting: code 0 is +4 dB, code 17 is +21 dB
  localparam logic [4:0] STL_FS_CODE_MAX = 5'h11;
  localparam logic [15:0] STL_GAIN_MIN_DB = 16'h0004;
  // headroom: code 0 is +20 %, code 16 is -20 %, steps of 2.5 %
  localparam logic [4:0] STL_HR_CODE_MAX = 5'h10;
  // code 0 keeps 32/40 of the supply, i.e. 80 %
  localparam logic [5:0] STL_HR_BASE = 6'h20;
  // 65536 / 40, used to divide by forty
  localparam logic [10:0] STL_RECIP40 = 11'h666;

  // levels are carried in 1/16 dB; one octave is 96 of those
  localparam int STL_DB_FRAC = 4;
  localparam logic [15:0] STL_OCT_Q4 = 16'h0060;
  // full scale of a 24-bit sample, 23 octaves above one lsb
  localparam logic [15:0] STL_FS_OCT_Q4 = 16'h08a0;
  // reference of the output level at 0 dB setting, in 1/16 dB re 1 mV
  localparam logic signed [15:0] STL_MPO_BASE_Q4 = 16'sh03fb;
  // gain table step, in 1/16 dB, between adjacent entries
  localparam logic [15:0] STL_EXP_STEP = 16'h0006;
  localparam logic [15:0] STL_SHIFT_MAX = 16'h0018;
  localparam logic [22:0] STL_MAG_MAX = 23'h7fffff;
  localparam int STL_GAIN_FRAC = 15;

  // 20*log10(1+k/16) in 1/16 dB
  localparam logic [15:0] STL_LOG_TAB [16] = '{
    16'h0000, 16'h0008, 16'h0010, 16'h0018,
    16'h001f, 16'h0026, 16'h002c, 16'h0033,
    16'h0038, 16'h003e, 16'h0044, 16'h0049,
    16'h004e, 16'h0052, 16'h0057, 16'h005b};
  // 2^(-k/16) as q1.15 linear gain
  localparam logic [15:0] STL_EXP_TAB [16] = '{
    16'h8000, 16'h7a93, 16'h7560, 16'h7067,
    16'h6ba2, 16'h6712, 16'h62b4, 16'h5e84,
    16'h5a82, 16'h56ac, 16'h52ff, 16'h4f7b,
    16'h4c1c, 16'h48e2, 16'h45cb, 16'h42d5};

  typedef struct packed {
    logic enable;
    logic lim_type;
    logic [4:0] fs_scale;
    logic [4:0] headroom;
    logic [3:0] fixed_thr;
    logic [3:0] knee_sel;
  } stl_cfg_type;

  typedef struct packed {
    logic [15:0] pvdd_mv;
    logic [15:0] vbat_mv;
    logic pvdd_active;
  } stl_supply_type;

endpackage

// *** rtl/stl_table_rom.sv ***
`timescale 1ns/1ps
module stl_table_rom #(
  parameter bit EXP_TABLE = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  output logic [15:0] data_o
);

  // one cycle read latency so the caller pipelines around it
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_o <= 16'h0000;
    end else if (EXP_TABLE) begin
      data_o <= stl_pkg::STL_EXP_TAB[addr_i];
    end else begin
      data_o <= stl_pkg::STL_LOG_TAB[addr_i];
    end
  end

endmodule

// *** rtl/stl_limiter.sv ***
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
// Operation
// - maximum peak output level comes from the full scale output setting
// - use the supply reading of whichever rail is currently active
// - headroom spans +20 % to -20 % in 2.5 % steps
// - target peak output is supply times 100 % minus headroom
// - target attenuation is 20 log of target over maximum peak
// - positive target attenuation is replaced by 0 dB
// - tracking limiter knee equals the target attenuation
// - below tracking knee samples pass, above it they are attenuated
// - tracking knee is recomputed whenever the target peak changes
// - target above maximum peak gives no tracking attenuation
// - fixed threshold spans 0 to -15 dBFS and equals the knee
// - fixed peak limit is maximum peak times 10^(threshold/20)
// - fixed limiter passes below threshold, attenuates above it
module stl_limiter (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire stl_pkg::stl_supply_type supply_i,
  input wire logic [23:0] sample_i,
  input wire logic sample_valid_i,
  output logic [23:0] sample_o,
  output logic sample_valid_o
);

  stl_pkg::stl_cfg_type cfg_reg;
  logic wr_pend_reg, rd_late_reg, bus_take, limiting_reg, over_knee;
  logic [7:0] wr_addr_reg, rd_addr_reg;
  logic [15:0] active_supply_level_reg, target_peak_output_log, in_log, att_amt, shift_full, gain;
  logic [16:0] target_peak_output_reg;
  logic [4:0] target_peak_output_msb_reg, msb1_reg, shift2_reg;
  logic signed [15:0] max_peak_output_db, att_raw, target_att_reg, fixed_knee;
  logic signed [15:0] fixed_peak_db_reg, knee_reg, in_db;
  logic [22:0] mag0_reg, mag1_reg, mag2_reg, out_mag;
  logic sign0_reg, v0_reg, sign1_reg, v1_reg, sign2_reg, lim2_reg, v2_reg;
  logic [3:0] exp_idx;
  logic [38:0] prod, scaled;

  // position of the highest set bit, zero for a zero input
  function automatic logic [4:0] msb_pos(input logic [23:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) begin
        pos = 5'(i);
      end
    end
    return pos;
  endfunction

  // the four bits just below the highest set bit
  function automatic logic [3:0] mant4(input logic [23:0] v,
                                       input logic [4:0] pos);
    logic [23:0] sh;
    sh = v << (5'd23 - pos);
    return sh[22:19];
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input stl_pkg::stl_cfg_type c,
                                         input logic lim,
                                         input logic [15:0] att,
                                         input logic [16:0] vt,
                                         input logic [15:0] fp);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      stl_pkg::STL_OFS_CTRL: begin
        d[stl_pkg::STL_CTRL_EN_BIT] = c.enable;
        d[stl_pkg::STL_CTRL_TYPE_BIT] = c.lim_type;
      end
      stl_pkg::STL_OFS_CFG: begin
        d[stl_pkg::STL_CFG_FS_LSB +: 5] = c.fs_scale;
        d[stl_pkg::STL_CFG_HR_LSB +: 5] = c.headroom;
        d[stl_pkg::STL_CFG_THR_LSB +: 4] = c.fixed_thr;
        d[stl_pkg::STL_CFG_KNEE_LSB +: 4] = c.knee_sel;
      end
      stl_pkg::STL_OFS_STAT: d = {att, 15'h0000, lim};
      // target peak saturates at 16 bits in the readback
      stl_pkg::STL_OFS_PEAK: d = {fp, (vt[16] ? 16'hffff : vt[15:0])};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  assign bus_take = hsel_i && hready_i && htrans_i[1];

  // address phase capture; writes land in the following data phase
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  // register writes; out of range codes are held at the nearest end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg_reg.enable <= 1'b0;
      cfg_reg.lim_type <= 1'b0;
      cfg_reg.fs_scale <= stl_pkg::STL_FS_RESET;
      cfg_reg.headroom <= stl_pkg::STL_HR_RESET;
      cfg_reg.fixed_thr <= stl_pkg::STL_THR_RESET;
      cfg_reg.knee_sel <= stl_pkg::STL_KNEE_RESET;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        stl_pkg::STL_OFS_CTRL: begin
          cfg_reg.enable <= hwdata_i[stl_pkg::STL_CTRL_EN_BIT];
          cfg_reg.lim_type <= hwdata_i[stl_pkg::STL_CTRL_TYPE_BIT];
        end
        stl_pkg::STL_OFS_CFG: begin
          cfg_reg.fs_scale <=
            (hwdata_i[stl_pkg::STL_CFG_FS_LSB +: 5] > stl_pkg::STL_FS_CODE_MAX)
            ? stl_pkg::STL_FS_CODE_MAX
            : hwdata_i[stl_pkg::STL_CFG_FS_LSB +: 5];
          cfg_reg.headroom <=
            (hwdata_i[stl_pkg::STL_CFG_HR_LSB +: 5] > stl_pkg::STL_HR_CODE_MAX)
            ? stl_pkg::STL_HR_CODE_MAX
            : hwdata_i[stl_pkg::STL_CFG_HR_LSB +: 5];
          cfg_reg.fixed_thr <= hwdata_i[stl_pkg::STL_CFG_THR_LSB +: 4];
          cfg_reg.knee_sel <= hwdata_i[stl_pkg::STL_CFG_KNEE_LSB +: 4];
        end
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // reads answer at once, except a read right behind a write waits a
  // cycle so it never returns the value from before that write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0; // only okay answers exist on this slave
      rd_late_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else if (rd_late_reg) begin
      hrdata_o <= rd_mux(rd_addr_reg, cfg_reg, limiting_reg,
                         target_att_reg, target_peak_output_reg, fixed_peak_db_reg);
      hreadyout_o <= 1'b1;
      rd_late_reg <= 1'b0;
    end else if (bus_take && !hwrite_i && wr_pend_reg) begin
      hreadyout_o <= 1'b0;
      rd_late_reg <= 1'b1;
      rd_addr_reg <= haddr_i[7:0];
    end else if (bus_take && !hwrite_i) begin
      hrdata_o <= rd_mux(haddr_i[7:0], cfg_reg, limiting_reg,
                         target_att_reg, target_peak_output_reg, fixed_peak_db_reg);
    end
  end

  // supply tracking: rail pick, headroom scaling
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      active_supply_level_reg <= 16'h0000;
      target_peak_output_reg <= 17'h00000;
      target_peak_output_msb_reg <= 5'h00;
    end else begin
      active_supply_level_reg <= supply_i.pvdd_active ? supply_i.pvdd_mv
                                       : supply_i.vbat_mv;
      target_peak_output_reg <= 17'((33'(active_supply_level_reg) *
                       33'(stl_pkg::STL_HR_BASE + 6'(cfg_reg.headroom)) *
                       33'(stl_pkg::STL_RECIP40)) >> 16);
      target_peak_output_msb_reg <= msb_pos({7'h00, target_peak_output_reg});
    end
  end

  stl_table_rom #(
    .EXP_TABLE(1'b0)
  ) u_supply_log (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(mant4({7'h00, target_peak_output_reg}, msb_pos({7'h00, target_peak_output_reg}))),
    .data_o(target_peak_output_log)
  );

  // target and maximum peak are compared in the log domain, so that ratio needs no divider
  assign max_peak_output_db = stl_pkg::STL_MPO_BASE_Q4 +
    signed'(16'((stl_pkg::STL_GAIN_MIN_DB + 16'(cfg_reg.fs_scale))
                << stl_pkg::STL_DB_FRAC));
  assign att_raw = signed'(16'(16'(target_peak_output_msb_reg) * stl_pkg::STL_OCT_Q4)
                           + target_peak_output_log) - max_peak_output_db;
  assign fixed_knee = -signed'(16'(16'(cfg_reg.fixed_thr)
                                   << stl_pkg::STL_DB_FRAC));

  // clamp to no gain, then pick the knee of the selected limiter; the
  // compressor knee field is stored only, it is assumed at full scale
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      target_att_reg <= 16'sh0000;
      knee_reg <= 16'sh0000;
      fixed_peak_db_reg <= 16'sh0000;
    end else begin
      target_att_reg <= (att_raw > 16'sh0000) ? 16'sh0000 : att_raw;
      knee_reg <= cfg_reg.lim_type ? fixed_knee
                                   : target_att_reg;
      fixed_peak_db_reg <= max_peak_output_db + fixed_knee;
    end
  end

  // sample stage 0: magnitude and sign, -full scale folds to +max
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mag0_reg <= 23'h000000;
      sign0_reg <= 1'b0;
      v0_reg <= 1'b0;
    end else begin
      v0_reg <= sample_valid_i;
      sign0_reg <= sample_i[23];
      if (sample_i == 24'h800000) begin
        mag0_reg <= stl_pkg::STL_MAG_MAX;
      end else begin
        mag0_reg <= sample_i[23] ? 23'(-sample_i) : sample_i[22:0];
      end
    end
  end

  stl_table_rom #(
    .EXP_TABLE(1'b0)
  ) u_sample_log (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(mant4({1'b0, mag0_reg}, msb_pos({1'b0, mag0_reg}))),
    .data_o(in_log)
  );

  // sample stage 1: log aligns with the rom read
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mag1_reg <= 23'h000000;
      msb1_reg <= 5'h00;
      sign1_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else begin
      mag1_reg <= mag0_reg;
      msb1_reg <= msb_pos({1'b0, mag0_reg});
      sign1_reg <= sign0_reg;
      v1_reg <= v0_reg;
    end
  end

  // input level in dBFS and the amount above the knee
  assign in_db = signed'(16'(16'(msb1_reg) * stl_pkg::STL_OCT_Q4) + in_log
                         - stl_pkg::STL_FS_OCT_Q4);
  assign over_knee = cfg_reg.enable && (in_db > knee_reg);
  assign att_amt = over_knee ? 16'(in_db - knee_reg) : 16'h0000;
  assign shift_full = att_amt / stl_pkg::STL_OCT_Q4;
  assign exp_idx = 4'((att_amt % stl_pkg::STL_OCT_Q4) / stl_pkg::STL_EXP_STEP);

  stl_table_rom #(
    .EXP_TABLE(1'b1)
  ) u_gain_exp (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(exp_idx),
    .data_o(gain)
  );

  // sample stage 2: octave shift beyond 24 gives a zero output anyway
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mag2_reg <= 23'h000000;
      shift2_reg <= 5'h00;
      sign2_reg <= 1'b0;
      lim2_reg <= 1'b0;
      v2_reg <= 1'b0;
    end else begin
      mag2_reg <= mag1_reg;
      shift2_reg <= (shift_full > stl_pkg::STL_SHIFT_MAX)
                    ? 5'(stl_pkg::STL_SHIFT_MAX) : 5'(shift_full);
      sign2_reg <= sign1_reg;
      lim2_reg <= over_knee;
      v2_reg <= v1_reg;
    end
  end

  assign prod = 39'(mag2_reg) * 39'(gain);
  assign scaled = (prod >> stl_pkg::STL_GAIN_FRAC) >> shift2_reg;
  assign out_mag = (scaled > 39'(stl_pkg::STL_MAG_MAX))
                   ? stl_pkg::STL_MAG_MAX : scaled[22:0];

  // output stage: sign restored, limiting flag kept per sample
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sample_o <= 24'h000000;
      sample_valid_o <= 1'b0;
      limiting_reg <= 1'b0;
    end else begin
      sample_valid_o <= v2_reg;
      sample_o <= sign2_reg ? 24'(-{1'b0, out_mag}) : {1'b0, out_mag};
      if (v2_reg) begin
        limiting_reg <= lim2_reg;
      end
    end
  end

  chk_no_gain_target: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    target_att_reg <= 16'sh0000)
    else $error("target attenuation went above zero");

  chk_rail_pick: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> active_supply_level_reg == ($past(supply_i.pvdd_active)
                               ? $past(supply_i.pvdd_mv)
                               : $past(supply_i.vbat_mv)))
    else $error("supply reading not from active rail");

  chk_zero_headroom: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cfg_reg.headroom == 5'h08) && $stable(cfg_reg.headroom)
    |=> (target_peak_output_reg <= 17'($past(active_supply_level_reg))) &&
        (target_peak_output_reg + 17'h00010 >= 17'($past(active_supply_level_reg))))
    else $error("zero headroom target differs from supply");

  chk_knee_tracks: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !cfg_reg.lim_type && $changed(target_att_reg)
    |=> knee_reg == $past(target_att_reg))
    else $error("tracking knee did not follow target");

  chk_fixed_knee: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cfg_reg.lim_type ##1 cfg_reg.lim_type |-> knee_reg == $past(fixed_knee))
    else $error("fixed knee not set from threshold");

  chk_no_track_att: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    v1_reg && !cfg_reg.lim_type && knee_reg == 16'sh0000
    |=> !lim2_reg)
    else $error("attenuation with no tracking need");

  chk_pass_below: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    v2_reg && !lim2_reg |=> sample_valid_o &&
      sample_o == ($past(sign2_reg) ? 24'(-{1'b0, $past(mag2_reg)})
                                     : {1'b0, $past(mag2_reg)}))
    else $error("sample below knee was altered");

  chk_limit_shrinks: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    v2_reg && lim2_reg |-> out_mag <= mag2_reg)
    else $error("limited sample grew");

  chk_stream_latency: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    sample_valid_i |-> ##4 sample_valid_o)
    else $error("sample lost in the limiter pipeline");

endmodule

// *** verification/stl_supply_model.sv ***
`timescale 1ns/1ps
// stand-in for the measurement converter feeding both rail readings
module stl_supply_model (
  input wire logic clk_i,
  input wire logic [15:0] pvdd_mv_i,
  input wire logic [15:0] vbat_mv_i,
  input wire logic pvdd_active_i,
  output stl_pkg::stl_supply_type supply_o
);
  // results change only at a conversion edge, never mid-cycle
  always_ff @(posedge clk_i) begin
    supply_o <= '{pvdd_mv_i, vbat_mv_i, pvdd_active_i};
  end
endmodule

// *** verification/stl_limiter_test.sv ***
`timescale 1ns/1ps
module stl_limiter_test;
  typedef struct {int val; int tol; int t;} stl_note_type;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [15:0] pvdd = 16'h0;
  logic [15:0] vbat = 16'h0;
  logic pvdd_act = 1'b1;
  stl_pkg::stl_supply_type supply_i;
  logic [23:0] sample_i = 24'h0;
  logic sample_valid_i = 1'b0;
  logic [23:0] sample_o;
  logic sample_valid_o;
  logic [31:0] rdata;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 74942;
  int codes[3] = '{3, 6, 15};
  real a;
  stl_note_type nt;
  stl_note_type notes[$];

  stl_supply_model adc (.clk_i(clk_i), .pvdd_mv_i(pvdd), .vbat_mv_i(vbat),
    .pvdd_active_i(pvdd_act), .supply_o(supply_i));
  stl_limiter uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .supply_i(supply_i), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o));

  // free-running clock and edge counter for latency checks
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_word(input string w, input logic [31:0] e,
                            input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  // tolerance covers the coarse log and gain tables inside the block
  task automatic check_near(input string w, input int e,
                            input logic signed [31:0] g, input int tol);
    n_checks++;
    if ((^g === 1'bx) || g < e - tol || g > e + tol) begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", w, e, g);
    end
  endtask

  // single transfer; only the watchdog ends a wait on a silent slave
  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, ad};
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    do @(posedge clk_i);
    while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i);
    while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check_near("okay response", 0, {31'h0, hresp_o}, 0);
  endtask

  function automatic logic [31:0] cfgw(input logic [4:0] fs,
                                       input logic [4:0] hr,
                                       input logic [3:0] thr);
    return {12'h0, thr, 3'h0, hr, 3'h0, fs};
  endfunction

  // expected target attenuation in 1/16 dB, never positive
  function automatic real att_of(input int vs, input int hr, input int fs);
    real r;
    r = 320.0 * $log10((vs * (32 + hr) * 1638) / 65536);
    r = r - (1019 + 16 * (4 + fs));
    return (r > 0.0) ? 0.0 : r;
  endfunction

  // thr is the limit magnitude; 0 means no limiting expected
  task automatic send(input int x, input real thr);
    stl_note_type n;
    n.t = cyc + 1; // the block takes the sample at the next edge
    n.tol = 0;
    n.val = (x == -8388608) ? -8388607 : x;
    if (thr > 0.0 && (x < 0 ? -x : x) > thr) begin
      n.val = (x < 0) ? -$rtoi(thr) : $rtoi(thr);
      n.tol = $rtoi(thr / 8.0);
    end
    notes.push_back(n);
    sample_i <= x[23:0];
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
  endtask

  // back-to-back samples, skipping levels too near the knee to judge
  task automatic stream(input int cnt, input real thr);
    int x;
    for (int i = 0; i < cnt; i++) begin
      do x = $random(seed) >>> 8;
      while (thr > 0.0 && (x < 0 ? -x : x) > 0.8 * thr &&
             (x < 0 ? -x : x) <= 1.25 * thr);
      send(x, thr);
    end
    sample_valid_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // result watcher: oldest note against each output pulse
  always @(posedge clk_i) begin
    if (sample_valid_o === 1'b1) begin
      if (notes.size() == 0) begin
        check_near("unexpected sample", 0, 1, 0);
      end else begin
        nt = notes.pop_front();
        check_near("sample", nt.val, $signed(sample_o), nt.tol);
        check_near("latency", 4, cyc - nt.t, 0);
      end
    end
  end

  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, stl_pkg::STL_OFS_CTRL, 32'h0, rdata);
    check_word("ctrl reset", 32'h0, rdata);
    bus(1'b0, stl_pkg::STL_OFS_CFG, 32'h0, rdata);
    check_word("cfg reset", 32'h00000800, rdata);
    bus(1'b1, 8'h40, 32'hffffffff, rdata);
    bus(1'b0, 8'h40, 32'h0, rdata);
    check_word("unmapped", 32'h0, rdata);
    send(-8388608, 0.0);
    stream(24, 0.0);
    // headroom steps and full-scale setting against both peak figures
    pvdd <= 16'd2000;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, stl_pkg::STL_OFS_CFG, cfgw(3 * i, 8 * i, 5 * i), rdata);
      repeat (8) @(posedge clk_i);
      bus(1'b0, stl_pkg::STL_OFS_PEAK, 32'h0, rdata);
      check_near("target peak", 2000 * (32 + 8 * i) * 1638 / 65536,
        {16'h0, rdata[15:0]}, 0);
      check_near("fixed peak", 1019 + 16 * (4 + 3 * i) - 80 * i,
        $signed(rdata[31:16]), 0);
      bus(1'b0, stl_pkg::STL_OFS_STAT, 32'h0, rdata);
      check_near("attenuation", $rtoi(att_of(2000, 8 * i, 3 * i)),
        $signed(rdata[31:16]), 12);
    end
    bus(1'b1, stl_pkg::STL_OFS_CTRL, 32'h3, rdata);
    foreach (codes[k]) begin
      bus(1'b1, stl_pkg::STL_OFS_CFG, cfgw(0, 8, codes[k]), rdata);
      a = 2.0 ** (23.0 - codes[k] / 6.0);
      stream(16, a);
      // a full-scale sample must leave the limiting flag set
      send(8388607, a);
      sample_valid_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      bus(1'b0, stl_pkg::STL_OFS_STAT, 32'h0, rdata);
      check_word("limiting", 32'h1, {31'h0, rdata[0]});
    end
    // tracking: ample supply first, then low battery readings with the battery rail made active
    bus(1'b1, stl_pkg::STL_OFS_CTRL, 32'h1, rdata);
    bus(1'b1, stl_pkg::STL_OFS_CFG, cfgw(0, 8, 0), rdata);
    pvdd <= 16'd5000;
    vbat <= 16'd1000;
    repeat (8) @(posedge clk_i);
    bus(1'b0, stl_pkg::STL_OFS_STAT, 32'h0, rdata);
    check_near("attenuation", 0, $signed(rdata[31:16]), 0);
    stream(16, 0.0);
    bus(1'b0, stl_pkg::STL_OFS_STAT, 32'h0, rdata);
    check_word("limiting", 32'h0, {31'h0, rdata[0]});
    for (int v = 1000; v <= 1500; v += 500) begin
      vbat <= v[15:0];
      pvdd_act <= 1'b0;
      repeat (8) @(posedge clk_i);
      a = att_of(v, 8, 0);
      bus(1'b0, stl_pkg::STL_OFS_STAT, 32'h0, rdata);
      check_near("attenuation", $rtoi(a), $signed(rdata[31:16]), 12);
      stream(16, 2.0 ** (23.0 + a / 96.0));
    end
    bus(1'b1, stl_pkg::STL_OFS_CTRL, 32'h0, rdata);
    check_near("pending", 0, notes.size(), 0);
    tally_and_finish();
  end
endmodule
